// ===== hw/ctdp_pkg.sv
// constants and carrier types for the cordless test and debug port
package ctdp_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LB3_DELAY_NS  = 1620000;
	localparam int LB3_DELAY_CYC = LB3_DELAY_NS / CLK_PERIOD_NS;

	// register map (byte addresses)
	localparam int         ADDR_W     = 8;
	localparam logic [7:0] OFS_ROUTE  = 8'h00;
	localparam logic [7:0] OFS_MODULATOR_TEST_CONTROL = 8'h04;
	localparam logic [7:0] OFS_INJMON = 8'h08;
	localparam logic [7:0] OFS_MEC1   = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] REG_RESET  = 8'h00;

	// field positions
	localparam int ROUTE_MODE_LO = 5;
	localparam int ROUTE_ENC_DIS = 7;
	localparam int ROUTE_TXSEL_LO = 2;
	localparam int MOD_TEST_BIT  = 2;
	localparam int MOD_PAT_LO    = 0;
	localparam int INJ_DRIVE_BIT = 1;
	localparam int INJ_ALL_BIT   = 0;
	localparam int MEC1_MOD_BIT  = 5;
	localparam int STAT_EMU      = 0;
	localparam int STAT_MOD_ON   = 1;
	localparam int STAT_LB3_RDY  = 2;

	// encodings
	localparam logic [1:0] MODE_VOICE = 2'h0;
	localparam logic [1:0] MODE_DCHAN = 2'h2;
	localparam logic [1:0] MODE_TXDIG = 2'h3;
	localparam logic [1:0] PAT_ZERO   = 2'h0;
	localparam logic [1:0] PAT_ONE    = 2'h1;
	localparam logic [1:0] PAT_ALT    = 2'h2;
	localparam logic [1:0] PAT_EXT    = 2'h3;
	localparam logic [1:0] TXSEL_LB3  = 2'h2;

	// slot flags of a frame; all clear means preamble
	typedef struct packed {
		logic ctrl;
		logic voice;
		logic marker;
		logic sync_w;
	} ctdp_slot_t;

	// multifunction pin drive
	typedef struct packed {
		logic [5:0] out;
		logic [5:0] oe;
	} ctdp_mpin_t;

	// microcontroller side pins and enables
	typedef struct packed {
		logic [5:0] port_oe;
		logic       ale_is_input;
		logic       cs0;
		logic       cs1;
		logic       cs2;
		logic       wdog_en;
		logic       timer_in_en;
		logic       iram_en;
	} ctdp_mcu_t;

	// results handed to the formatter and modulator
	typedef struct packed {
		logic inj_bit;
		logic inj_strobe;
		logic voice_bit;
		logic voice_strobe;
		logic mod_data;
		logic mod_test_on;
		logic base_station_role;
	} ctdp_core_t;

endpackage

// ===== hw/ctdp_top.sv
// test, debug and emulation port logic with apb register access
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ctdp_top #(
	parameter int LB3_DELAY = ctdp_pkg::LB3_DELAY_CYC
) (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [ctdp_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata,
	output var  logic                         pready,
	output var  logic                         pslverr,
	// emulation strap and cpu side sources
	input  wire logic                         emu_strap_n,
	input  wire logic [2:0]                   cs_int,
	input  wire logic                         irq0_int,
	input  wire logic                         irq1_int,
	input  wire logic                         cpu_clk_int,
	output var  ctdp_pkg::ctdp_mcu_t          mcu_o,
	// timing sources from outside this domain
	input  wire logic                         link_clk_72k,
	input  wire logic                         voice_bit_clock,
	input  wire logic                         frame_clock_8k,
	// formatter side
	input  wire logic                         fmt_tx_bit,
	input  wire logic                         fmt_tx_valid,
	input  wire logic                         fmt_rx_bit,
	input  wire logic                         voice_rx_bit,
	input  wire ctdp_pkg::ctdp_slot_t         tx_slot,
	input  wire ctdp_pkg::ctdp_slot_t         rx_slot,
	output var  ctdp_pkg::ctdp_core_t         core_o,
	// multifunction pins
	input  wire logic [5:0]                   mpin_in,
	output var  ctdp_pkg::ctdp_mpin_t         mpin_o
);

	// synchronisers: strap, link clk, bit clk, frame clk, pin 5, pin 1
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic [5:0] sync3_r;
	always_ff @(posedge clock)
	begin
		sync1_r <= {emu_strap_n, link_clk_72k, voice_bit_clock, frame_clock_8k,
			mpin_in[5], mpin_in[1]};
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end
	logic strap_s;
	logic lclk_s;
	logic lclk_d;
	logic bclk_s;
	logic bclk_d;
	logic fclk_d;
	logic pin5_s;
	logic pin1_s;
	assign strap_s = sync2_r[5];
	assign lclk_s  = sync2_r[4];
	assign lclk_d  = sync3_r[4];
	assign bclk_s  = sync2_r[3];
	assign bclk_d  = sync3_r[3];
	assign fclk_d  = sync3_r[2];
	assign pin5_s  = sync2_r[1];
	assign pin1_s  = sync2_r[0];
	logic lrise;
	logic lfall;
	logic brise;
	assign lrise = lclk_s & ~lclk_d;
	assign lfall = ~lclk_s & lclk_d;
	assign brise = bclk_s & ~bclk_d;

	// registers and apb
	logic [7:0]  route_r, route_nxt;
	logic [7:0]  modulator_test_control_r, modulator_test_control_nxt;
	logic [7:0]  injmon_r, injmon_nxt;
	logic [7:0]  mec1_r, mec1_nxt;
	logic        in_rst_r, in_rst_nxt;
	logic        emu_r, emu_nxt;
	logic [31:0] prdata_nxt;
	logic        pready_nxt;
	logic        pslverr_nxt;
	logic        lb3_rdy_r;
	logic        mod_on_r;
	logic        setup;
	logic        wr_acc;
	logic        hit;
	logic [7:0]  rd_val;

	always_comb
	begin
		route_nxt   = route_r;
		modulator_test_control_nxt  = modulator_test_control_r;
		injmon_nxt  = injmon_r;
		mec1_nxt    = mec1_r;
		in_rst_nxt  = 1'b0;
		emu_nxt     = emu_r;
		// strap caught at the first edge after release; synchroniser runs in reset
		if (in_rst_r)
			emu_nxt = ~strap_s;
		setup  = psel & ~penable;
		wr_acc = psel & penable & pready & pwrite;
		hit    = 1'b1;
		rd_val = 8'h00;
		case (paddr)
			ctdp_pkg::OFS_ROUTE:  rd_val = route_r;
			ctdp_pkg::OFS_MODULATOR_TEST_CONTROL: rd_val = modulator_test_control_r;
			ctdp_pkg::OFS_INJMON: rd_val = injmon_r;
			ctdp_pkg::OFS_MEC1:   rd_val = mec1_r;
			ctdp_pkg::OFS_STATUS:
			begin
				rd_val[ctdp_pkg::STAT_EMU]     = emu_r;
				rd_val[ctdp_pkg::STAT_MOD_ON]  = mod_on_r;
				rd_val[ctdp_pkg::STAT_LB3_RDY] = lb3_rdy_r;
			end
			default: hit = 1'b0;
		endcase
		if (wr_acc)
		begin
			case (paddr)
				ctdp_pkg::OFS_ROUTE:  route_nxt  = pwdata[7:0];
				ctdp_pkg::OFS_MODULATOR_TEST_CONTROL: modulator_test_control_nxt = pwdata[7:0];
				ctdp_pkg::OFS_INJMON: injmon_nxt = pwdata[7:0];
				ctdp_pkg::OFS_MEC1:   mec1_nxt   = pwdata[7:0];
				default: ;
			endcase
		end
		// no wait state: answer is prepared during setup
		pready_nxt  = setup;
		prdata_nxt  = setup ? {24'h00_0000, rd_val} : prdata;
		pslverr_nxt = setup & ~hit;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			route_r  <= ctdp_pkg::REG_RESET;
			modulator_test_control_r <= ctdp_pkg::REG_RESET;
			injmon_r <= ctdp_pkg::REG_RESET;
			mec1_r   <= ctdp_pkg::REG_RESET;
			in_rst_r <= 1'b1;
			emu_r    <= 1'b0;
			prdata   <= 32'h0000_0000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end
		else
		begin
			route_r  <= route_nxt;
			modulator_test_control_r <= modulator_test_control_nxt;
			injmon_r <= injmon_nxt;
			mec1_r   <= mec1_nxt;
			in_rst_r <= in_rst_nxt;
			emu_r    <= emu_nxt;
			prdata   <= prdata_nxt;
			pready   <= pready_nxt;
			pslverr  <= pslverr_nxt;
		end
	end

	// decoded controls
	logic [1:0] mode;
	logic [1:0] pattern;
	logic       mod_test;
	logic       inj_drive;
	logic       inj_all;
	logic       enc_on;
	logic       tx_gate;
	logic       rx_gate;
	assign mode      = route_r[ctdp_pkg::ROUTE_MODE_LO +: 2];
	assign pattern   = modulator_test_control_r[ctdp_pkg::MOD_PAT_LO +: 2];
	assign mod_test  = modulator_test_control_r[ctdp_pkg::MOD_TEST_BIT];
	assign inj_drive = injmon_r[ctdp_pkg::INJ_DRIVE_BIT];
	assign inj_all   = injmon_r[ctdp_pkg::INJ_ALL_BIT];
	assign enc_on    = ~route_r[ctdp_pkg::ROUTE_ENC_DIS];
	// preamble slots never get a clock pulse
	assign tx_gate = tx_slot.ctrl | (inj_all & |tx_slot[2:0]);
	assign rx_gate = rx_slot.ctrl | (inj_all & |rx_slot[2:0]);

	// link datapath
	logic        txd_r, txd_nxt;
	logic        txv_r, txv_nxt;
	logic        mon_tx_r, mon_tx_nxt;
	logic        mon_rx_r, mon_rx_nxt;
	logic        alt_r, alt_nxt;
	logic        ext_r, ext_nxt;
	logic        mod_on_nxt;
	logic        lb3_rdy_nxt;
	logic [15:0] lb3_cnt_r, lb3_cnt_nxt;
	ctdp_pkg::ctdp_core_t core_nxt;

	always_comb
	begin
		txd_nxt    = txd_r;
		txv_nxt    = txv_r;
		mon_tx_nxt = mon_tx_r;
		mon_rx_nxt = mon_rx_r;
		alt_nxt    = alt_r;
		ext_nxt    = ext_r;
		core_nxt   = core_o;
		core_nxt.inj_strobe   = 1'b0;
		core_nxt.voice_strobe = 1'b0;
		if (lrise)
		begin
			txd_nxt = fmt_tx_bit;
			txv_nxt = fmt_tx_valid;
			alt_nxt = ~alt_r;
		end
		if (lfall)
		begin
			mon_tx_nxt = fmt_tx_bit;
			mon_rx_nxt = fmt_rx_bit;
			// external pattern moves on the rise, so take it mid bit
			ext_nxt = pin1_s;
		end
		// injected bits pass on one per strobe, in arrival order
		if (mode == ctdp_pkg::MODE_DCHAN && inj_drive && lrise && tx_gate)
		begin
			core_nxt.inj_bit    = pin1_s;
			core_nxt.inj_strobe = 1'b1;
		end
		if (mode == ctdp_pkg::MODE_VOICE && brise)
		begin
			core_nxt.voice_bit    = enc_on ? pin5_s : pin1_s;
			core_nxt.voice_strobe = 1'b1;
		end
		mod_on_nxt = mec1_r[ctdp_pkg::MEC1_MOD_BIT] & mod_test;
		core_nxt.mod_test_on = mod_on_nxt;
		case (pattern)
			ctdp_pkg::PAT_ZERO: core_nxt.mod_data = 1'b0;
			ctdp_pkg::PAT_ONE:  core_nxt.mod_data = 1'b1;
			ctdp_pkg::PAT_ALT:  core_nxt.mod_data = alt_r;
			default:            core_nxt.mod_data = ext_r;
		endcase
		// loopback 3: counts the loop delay before reporting ready
		core_nxt.base_station_role = route_r[ctdp_pkg::ROUTE_TXSEL_LO +: 2] == ctdp_pkg::TXSEL_LB3;
		lb3_cnt_nxt = 16'h0000;
		lb3_rdy_nxt = 1'b0;
		if (core_nxt.base_station_role)
		begin
			lb3_rdy_nxt = lb3_cnt_r >= LB3_DELAY[15:0];
			lb3_cnt_nxt = lb3_rdy_nxt ? lb3_cnt_r : lb3_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			txd_r     <= 1'b0;
			txv_r     <= 1'b0;
			mon_tx_r  <= 1'b0;
			mon_rx_r  <= 1'b0;
			alt_r     <= 1'b0;
			ext_r     <= 1'b0;
			mod_on_r  <= 1'b0;
			lb3_rdy_r <= 1'b0;
			lb3_cnt_r <= 16'h0000;
			core_o    <= '0;
		end
		else
		begin
			txd_r     <= txd_nxt;
			txv_r     <= txv_nxt;
			mon_tx_r  <= mon_tx_nxt;
			mon_rx_r  <= mon_rx_nxt;
			alt_r     <= alt_nxt;
			ext_r     <= ext_nxt;
			mod_on_r  <= mod_on_nxt;
			lb3_rdy_r <= lb3_rdy_nxt;
			lb3_cnt_r <= lb3_cnt_nxt;
			core_o    <= core_nxt;
		end
	end

	// pins; clocks use the delayed sample so data and clock leave together
	ctdp_pkg::ctdp_mpin_t mpin_nxt;
	ctdp_pkg::ctdp_mcu_t  mcu_nxt;

	always_comb
	begin
		mpin_nxt = '0;
		case (mode)
			ctdp_pkg::MODE_VOICE:
			begin
				mpin_nxt.out[0] = voice_rx_bit;
				mpin_nxt.out[2] = bclk_d;
				mpin_nxt.out[3] = fclk_d;
				mpin_nxt.out[4] = voice_rx_bit;
				mpin_nxt.oe     = {1'b0, enc_on, 1'b1, 1'b1, 1'b0, 1'b1};
			end
			ctdp_pkg::MODE_TXDIG:
			begin
				mpin_nxt.out[0] = lclk_d;
				mpin_nxt.oe[0]  = 1'b1;
				// in test mode pin 1 is left as the pattern input
				mpin_nxt.out[1] = txd_r;
				mpin_nxt.out[2] = txv_r;
				mpin_nxt.oe[1]  = ~mod_test;
				mpin_nxt.oe[2]  = ~mod_test;
			end
			ctdp_pkg::MODE_DCHAN:
			begin
				mpin_nxt.out[0] = mon_rx_r;
				mpin_nxt.out[1] = mon_tx_r;
				mpin_nxt.out[2] = lclk_d & rx_gate;
				mpin_nxt.out[3] = lclk_d & tx_gate;
				mpin_nxt.oe     = {2'b00, 1'b1, 1'b1, ~inj_drive, 1'b1};
			end
			default: mpin_nxt = '0;
		endcase
		// emulation: ports released and chip selects repurposed
		mcu_nxt.port_oe      = emu_r ? 6'h00 : 6'h3f;
		mcu_nxt.ale_is_input = emu_r;
		mcu_nxt.cs0          = emu_r ? irq0_int : cs_int[0];
		mcu_nxt.cs1          = emu_r ? irq1_int : cs_int[1];
		mcu_nxt.cs2          = emu_r ? cpu_clk_int : cs_int[2];
		mcu_nxt.wdog_en      = ~emu_r;
		mcu_nxt.timer_in_en  = ~emu_r;
		mcu_nxt.iram_en      = ~emu_r;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mpin_o <= '0;
			mcu_o  <= '0;
		end
		else
		begin
			mpin_o <= mpin_nxt;
			mcu_o  <= mcu_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	strap_capture_a: assert property (in_rst_r |=> emu_r == !$past(strap_s))
		else $error("emulation flag not taken from strap");
	port_release_a: assert property (emu_r ##1 emu_r |-> mcu_o.port_oe == 6'h00 && mcu_o.ale_is_input)
		else $error("port buffers driven in emulation");
	cs_irq_a: assert property (emu_r ##1 emu_r |-> mcu_o.cs0 == $past(irq0_int))
		else $error("chip select 0 not carrying irq0");
	wdog_off_a: assert property (emu_r ##1 emu_r |-> !mcu_o.wdog_en && !mcu_o.iram_en)
		else $error("watchdog left on in emulation");
	mod_gate_a: assert property (core_o.mod_test_on |-> $past(mec1_r[ctdp_pkg::MEC1_MOD_BIT]))
		else $error("modulator test without enable");
	pat_ones_a: assert property ((pattern == ctdp_pkg::PAT_ONE) [*2] |-> core_o.mod_data)
		else $error("all ones pattern not ones");
	tx_strobe_a: assert property ((mode == ctdp_pkg::MODE_TXDIG && !mod_test && lrise) ##1
		(mode == ctdp_pkg::MODE_TXDIG && !mod_test) |=> mpin_o.out[2] == $past(fmt_tx_valid, 2))
		else $error("valid strobe not tracking transmit data");
	inject_take_a: assert property (mode == ctdp_pkg::MODE_DCHAN && inj_drive
		&& lrise && tx_gate |=> core_o.inj_strobe && core_o.inj_bit == $past(pin1_s))
		else $error("injected control bit missed");
	mon_fall_a: assert property ($changed(mon_tx_r) |-> $past(lfall))
		else $error("monitor data changed off falling edge");
	preamble_quiet_a: assert property (mode == ctdp_pkg::MODE_DCHAN
		##1 (mode == ctdp_pkg::MODE_DCHAN && $past(tx_slot) == '0) |-> !mpin_o.out[3])
		else $error("clock pulse during preamble");

endmodule
`default_nettype wire

// ===== bench/ctdp_partner.sv
// far-side test circuit model: clocks toward the port and pin drive
`timescale 1ns/10ps
`default_nettype none
module ctdp_partner (
	// data change edge: high moves on link rise
	input  wire logic       chg_rise,
	// clocks toward the device
	output var  logic       link_clk_72k,
	output var  logic       voice_bit_clock,
	output var  logic       frame_clock_8k,
	// values this circuit puts on the pins
	output var  logic [5:0] ext_pin
);
	logic [7:0] pat_r = 8'hb2;
	logic [5:0] pin_r = 6'h21;
	// one driver for the pin values
	assign ext_pin = pin_r;
	initial
	begin
		link_clk_72k = 1'h0;
		#137;
		forever #400 link_clk_72k = ~link_clk_72k;
	end
	initial
	begin
		voice_bit_clock = 1'h0;
		forever #800 voice_bit_clock = ~voice_bit_clock;
	end
	initial
	begin
		frame_clock_8k = 1'h0;
		forever #3200 frame_clock_8k = ~frame_clock_8k;
	end
	// moves away from the device's sampling edge; unused pins keep changing
	always @(link_clk_72k)
	begin
		if (link_clk_72k == chg_rise)
		begin
			pat_r <= {pat_r[6:0], pat_r[7]};
			pin_r <= {1'h1, ~pin_r[4:2], pat_r[7], ~pin_r[0]};
		end
	end
endmodule
`default_nettype wire

// ===== bench/ctdp_tb_top.sv
// self-checking bench for the test and debug port
`timescale 1ns/10ps
`default_nettype none
module ctdp_tb_top;
	logic                 clock;
	logic                 rst_n = 1'h0;
	logic                 psel = 1'h0;
	logic                 penable = 1'h0;
	logic                 pwrite = 1'h0;
	logic [7:0]           paddr = 8'h00;
	logic [31:0]          pwdata = 32'h0000_0000;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 emu_strap_n = 1'h1;
	logic [2:0]           cs_int = 3'h5;
	logic                 irq0_int = 1'h1;
	logic                 irq1_int = 1'h0;
	logic                 cpu_clk_int = 1'h1;
	ctdp_pkg::ctdp_mcu_t  mcu_o;
	logic                 link_clk_72k;
	logic                 voice_bit_clock;
	logic                 frame_clock_8k;
	logic                 fmt_tx_bit = 1'h0;
	logic                 fmt_tx_valid = 1'h0;
	logic                 fmt_rx_bit = 1'h1;
	logic                 voice_rx_bit = 1'h0;
	ctdp_pkg::ctdp_slot_t tx_slot = 4'h0;
	ctdp_pkg::ctdp_slot_t rx_slot = 4'h8;
	ctdp_pkg::ctdp_core_t core_o;
	logic [5:0]           mpin_in;
	ctdp_pkg::ctdp_mpin_t mpin_o;
	logic [5:0]           ext_pin;
	logic                 chg_rise = 1'h1;
	logic [31:0]          rd;
	logic                 er;
	logic                 b;
	logic                 e0;
	logic                 x0;
	logic [1:0]           ex;
	int                   mismatches = 0;
	int                   n_checks = 0;
	int                   cyc = 0;
	int                   n;
	logic [7:0]           ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};

	// a pin shows the device's level while it drives, else the far side's
	assign mpin_in = (mpin_o.oe & mpin_o.out) | (~mpin_o.oe & ext_pin);

	ctdp_top #(.LB3_DELAY(20)) uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .emu_strap_n, .cs_int, .irq0_int, .irq1_int,
		.cpu_clk_int, .mcu_o, .link_clk_72k, .voice_bit_clock, .frame_clock_8k, .fmt_tx_bit,
		.fmt_tx_valid, .fmt_rx_bit, .voice_rx_bit, .tx_slot, .rx_slot, .core_o, .mpin_in,
		.mpin_o);
	ctdp_partner partner (.chg_rise, .link_clk_72k, .voice_bit_clock, .frame_clock_8k,
		.ext_pin);

	initial
	begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	task automatic conclude;
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard, generous against roughly 700 cycles of work
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			mismatches++;
			conclude;
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask

	// setup, then access held until pready is seen or 20 cycles pass; released after that
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'h1 && k < 20);
		// ready, read data and error all taken at the same rising edge
		chk("pready", 8'h01, {7'h00, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, {24'h00_0000, d});
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(nm, e, rd[7:0]);
		chk("upper bits", 8'h00, {7'h00, |rd[31:8]});
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clock);
		emu_strap_n <= strap;
		rst_n <= 1'h0;
		repeat (10) @(posedge clock);
		rst_n <= 1'h1;
		repeat (3) @(posedge clock);
	endtask

	// value left on pin 1 just before a link rise, read some cycles later
	task automatic lnk;
		@(posedge link_clk_72k);
		b = mpin_in[1];
		repeat (6) @(negedge clock);
	endtask

	task automatic wait_inj;
		n = 0;
		while (core_o.inj_strobe !== 1'h1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
	endtask

	initial
	begin
		do_reset(1'h0);
		rdc("emu status", ctdp_pkg::OFS_STATUS, 8'h01);
		chk("port oe", 8'h00, {2'h0, mcu_o.port_oe});
		chk("emu pins", 8'h0d, {4'h0, mcu_o.ale_is_input, mcu_o.cs0, mcu_o.cs1, mcu_o.cs2});
		chk("wdog", 8'h00, {5'h00, mcu_o.wdog_en, mcu_o.timer_in_en, mcu_o.iram_en});
		do_reset(1'h1);
		rdc("status", ctdp_pkg::OFS_STATUS, 8'h00);
		chk("cs pins", {4'h0, 1'h0, cs_int},
			{4'h0, mcu_o.ale_is_input, mcu_o.cs2, mcu_o.cs1, mcu_o.cs0});
		foreach (ofs[i]) rdc("reset value", ofs[i], ctdp_pkg::REG_RESET);
		wr(ctdp_pkg::OFS_INJMON, 8'ha5);
		rdc("injmon rw", ctdp_pkg::OFS_INJMON, 8'ha5);
		apb(1'h0, 8'h14, 32'h0000_0000);
		chk("unmapped", 8'h01, {rd[7:1], er});
		wr(ctdp_pkg::OFS_MODULATOR_TEST_CONTROL, 8'h04);
		rdc("modulator_test_control rw", ctdp_pkg::OFS_MODULATOR_TEST_CONTROL, 8'h04);
		chk("mod off", 8'h00, {7'h00, core_o.mod_test_on});
		wr(ctdp_pkg::OFS_MEC1, 8'h20);
		wr(ctdp_pkg::OFS_ROUTE, 8'h60);
		rdc("mod status", ctdp_pkg::OFS_STATUS, 8'h02);
		chk("ramp bypass", 8'h01, {7'h00, core_o.mod_test_on});
		chk("test pins", 8'h01, {6'h00, mpin_o.oe[1:0]});
		for (int p = 0; p < 4; p++)
		begin
			wr(ctdp_pkg::OFS_MODULATOR_TEST_CONTROL, {6'h01, p[1:0]});
			lnk;
			lnk;
			x0 = core_o.mod_data;
			e0 = b;
			lnk;
			ex = (p == 0) ? 2'h0 : (p == 1) ? 2'h3 : (p == 2) ? {x0, ~x0} : {e0, b};
			chk("pattern", {6'h00, ex}, {6'h00, x0, core_o.mod_data});
		end
		wr(ctdp_pkg::OFS_MODULATOR_TEST_CONTROL, 8'h00);
		@(posedge clock);
		fmt_tx_bit <= 1'h1;
		fmt_tx_valid <= 1'h1;
		lnk;
		lnk;
		chk("tx digital", 8'h0f, {4'h0, mpin_o.out[2:1], mpin_o.oe[1:0]});
		@(posedge clock);
		fmt_tx_bit <= 1'h0;
		fmt_tx_valid <= 1'h0;
		lnk;
		lnk;
		chk("tx idle", 8'h03, {4'h0, mpin_o.out[2:1], mpin_o.oe[1:0]});
		wr(ctdp_pkg::OFS_ROUTE, 8'h00);
		@(posedge clock);
		voice_rx_bit <= 1'h1;
		repeat (80) @(negedge clock);
		chk("voice oe", 8'h1d, {2'h0, mpin_o.oe});
		chk("voice out", 8'h03, {6'h00, mpin_o.out[4], mpin_o.out[0]});
		while (core_o.voice_strobe !== 1'h1 && cyc < 29000) @(negedge clock);
		chk("voice in", 8'h01, {7'h00, core_o.voice_bit});
		wr(ctdp_pkg::OFS_ROUTE, 8'h40);
		wr(ctdp_pkg::OFS_INJMON, 8'h02);
		@(posedge clock);
		chg_rise <= 1'h0;
		tx_slot <= 4'h8;
		wait_inj;
		chk("inj strobe", 8'h01, {7'h00, core_o.inj_strobe});
		chk("inj bit", {7'h00, mpin_in[1]}, {7'h00, core_o.inj_bit});
		chk("tx clock oe", 8'h01, {7'h00, mpin_o.oe[3]});
		@(posedge clock);
		tx_slot <= 4'h0;
		wr(ctdp_pkg::OFS_INJMON, 8'h03);
		wait_inj;
		chk("preamble", 8'h00, {7'h00, core_o.inj_strobe});
		@(posedge clock);
		tx_slot <= 4'h2;
		wait_inj;
		chk("marker slot", 8'h01, {7'h00, core_o.inj_strobe});
		wr(ctdp_pkg::OFS_INJMON, 8'h00);
		repeat (4) @(negedge clock);
		chk("monitor oe", 8'h0f, {4'h0, mpin_o.oe[3:0]});
		wr(ctdp_pkg::OFS_ROUTE, 8'h20);
		repeat (4) @(negedge clock);
		chk("route 01", 8'h00, {2'h0, mpin_o.oe});
		wr(ctdp_pkg::OFS_ROUTE, 8'h08);
		rdc("lb3 early", ctdp_pkg::OFS_STATUS, 8'h00);
		repeat (30) @(negedge clock);
		rdc("lb3 done", ctdp_pkg::OFS_STATUS, 8'h04);
		chk("base role", 8'h01, {7'h00, core_o.base_station_role});
		conclude;
	end
endmodule
`default_nettype wire
